// ===== psm_pkg.sv
// shared constants and carrier types for the power saving mode controller
package psm_pkg;

    localparam int AXI_ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] MAIN_CLOCK_CTRL_STATUS_OFS = 8'h00;
    localparam logic [7:0] MAIN_CLOCK_CTRL_STATUS_ALIAS_OFS = 8'h04;
    localparam logic [7:0] POWER_STATUS_OFS = 8'h08;

    // main_clock_ctrl_status fields
    localparam int SLOW_MODE_SELECT_BIT = 0;
    localparam int SLOW_FREQ_SEL_LSB = 1;
    localparam int OSC_IRQ_ENABLE_BIT = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // power status fields
    localparam int STATUS_MODE_LSB = 0;
    localparam int STATUS_SLOW_BIT = 3;
    localparam int STATUS_CAUSE_BIT = 4;

    // divider exponents: core clock is oscillator / 2**exp
    localparam logic [2:0] RUN_DIV_EXP = 3'h1;
    localparam logic [2:0] SLOW_DIV_EXP_BASE = 3'h2;
    localparam logic [2:0] DIV_EXP_RESET = 3'h1;

    // restart delay, in core clock cycles
    localparam int STARTUP_CYCLES = 4096;
    localparam int STARTUP_CNT_W = 13;

    // interrupt level pattern meaning level 0, interrupts enabled
    localparam logic [1:0] IRQ_LEVEL_ZERO = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PSM_RUN,
        PSM_WAIT,
        PSM_HALT,
        PSM_ACTIVE_HALT,
        PSM_STARTUP
    } psm_mode_t;

    typedef struct packed {
        logic awvalid;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [AXI_ADDR_W-1:0] araddr;
        logic rready;
    } psm_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } psm_axi_rsp_t;

    typedef struct packed {
        logic haltInstr;
        logic waitForInterruptInstr;
    } psm_cpu_req_t;

    typedef struct packed {
        logic extIrq;
        logic haltExitIrq;
        logic oscTimebaseIrq;
        logic anyIrq;
        logic resetReq;
    } psm_wake_t;

    typedef struct packed {
        logic oscEnable;
        logic cpuClkEn;
        logic periphClkEn;
        logic canClkEn;
        logic timebaseClkEn;
    } psm_clk_gate_t;

    typedef struct packed {
        logic irqLevelForce;
        logic [1:0] irqLevel;
        logic wdgResetReq;
        logic resume;
        logic resumeToReset;
    } psm_cpu_rsp_t;

    typedef struct packed {
        logic [4:0] cnt;
        logic [2:0] curExp;
        logic coreTick;
        logic baseTick;
    } psm_div_state_t;

endpackage : psm_pkg

// ===== psm_clk_div.sv
// oscillator divider producing core and base clock enables
`timescale 1ns/1ps
module psm_clk_div (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic run,
    input wire logic [2:0] divExp,
    output logic coreTick,
    output logic baseTick
);

    psm_pkg::psm_div_state_t st;
    psm_pkg::psm_div_state_t next_st;

    always_comb begin
        logic [5:0] span;
        span = 6'h00;
        next_st = st;
        next_st.coreTick = 1'b0;
        next_st.baseTick = 1'b0;
        span = 6'((6'h01 << st.curExp) - 6'h01);
        if (run) begin
            next_st.cnt = 5'(st.cnt + 5'h01);
            // ratios are even, so bit 0 always gives oscillator / 2
            next_st.baseTick = st.cnt[0];
            if ({1'b0, st.cnt} == span) begin
                next_st.coreTick = 1'b1;
                next_st.cnt = 5'h00;
                // new ratio taken only at a period end, so no short pulse
                next_st.curExp = divExp;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st.cnt <= 5'h00;
            st.curExp <= psm_pkg::DIV_EXP_RESET;
            st.coreTick <= 1'b0;
            st.baseTick <= 1'b0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign coreTick = st.coreTick;
    assign baseTick = st.baseTick;

endmodule : psm_clk_div

// ===== psm_power_ctrl.sv
// power saving mode controller with its register slave
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps

// Behaviour
// - after reset: run mode, core clock is oscillator divided by two
// - halt variants entered only by the halt instruction, chosen by oscillator irq enable
// - halt with oscillator irq enable 0 gives halt, with 1 gives active-halt
// - entering either halt forces interrupt level bits to 10
// - halt left only on external irq, halt-exit irq, or reset
// - after halt wake-up wait 4096 core cycles before the cpu resumes
// - after the delay cpu services the waking irq or fetches reset vector
// - standard halt stops oscillator and all internal clocks
// - halt with watchdog on and oscillator irq off gives watchdog reset
// - leaving standard halt restarts oscillator at once, delay lets it settle
// - active-halt keeps oscillator and time base; time-base irq wakes
// - active-halt with watchdog active causes no reset
// - wait instruction stops cpu only, peripherals keep clocking
// - entering wait forces level bits to 10, nothing else touched
// - wait ends on irq or reset, then cpu jumps to the irq service routine or fetches reset vector
// - slow mode divides oscillator by 4, 8, 16 or 32 instead of 2
// - in slow mode all but the CAN clock run at the reduced rate
// - level pattern 10 means level 0, interrupts enabled
module psm_power_ctrl #(
    parameter int STARTUP_LEN = psm_pkg::STARTUP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire psm_pkg::psm_axi_req_t axiReq,
    output psm_pkg::psm_axi_rsp_t axiRsp,
    input wire psm_pkg::psm_cpu_req_t cpuReq,
    input wire psm_pkg::psm_wake_t wake,
    input wire logic watchdogEnabled,
    output psm_pkg::psm_clk_gate_t clkGate,
    output psm_pkg::psm_cpu_rsp_t cpuRsp
);

    typedef struct packed {
        psm_pkg::psm_mode_t mode;
        logic [psm_pkg::CTRL_W-1:0] ctrl;
        logic [psm_pkg::STARTUP_CNT_W-1:0] startCnt;
        logic wakeByReset;
        logic oscOn;
        logic cpuGate;
        logic periphGate;
        logic awHeld;
        logic [psm_pkg::AXI_ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irqLevelForce;
        logic wdgResetReq;
        logic resume;
        logic resumeToReset;
    } psm_ctrl_state_t;

    localparam logic [psm_pkg::STARTUP_CNT_W-1:0] STARTUP_LAST = psm_pkg::STARTUP_CNT_W'(STARTUP_LEN - 1);

    psm_ctrl_state_t st;
    psm_ctrl_state_t next_st;
    logic coreTick;
    logic baseTick;
    logic [2:0] divExp;
    logic slowSel;
    logic oscIrqEnable;

    // both control offsets reach the same storage
    function automatic logic isCtrlAddr(input logic [psm_pkg::AXI_ADDR_W-1:0] addr);
        isCtrlAddr = (addr == psm_pkg::MAIN_CLOCK_CTRL_STATUS_OFS) ||
                     (addr == psm_pkg::MAIN_CLOCK_CTRL_STATUS_ALIAS_OFS);
    endfunction : isCtrlAddr

    function automatic logic isStatusAddr(input logic [psm_pkg::AXI_ADDR_W-1:0] addr);
        isStatusAddr = (addr == psm_pkg::POWER_STATUS_OFS);
    endfunction : isStatusAddr

    assign slowSel = st.ctrl[psm_pkg::SLOW_MODE_SELECT_BIT];
    assign oscIrqEnable = st.ctrl[psm_pkg::OSC_IRQ_ENABLE_BIT];

    // 00..11 map in order onto /4, /8, /16, /32
    assign divExp = slowSel ?
        3'(psm_pkg::SLOW_DIV_EXP_BASE + {1'b0, st.ctrl[psm_pkg::SLOW_FREQ_SEL_LSB +: 2]}) :
        psm_pkg::RUN_DIV_EXP;

    psm_clk_div u_div (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clkEn(clkEn),
        .run(st.oscOn),
        .divExp(divExp),
        .coreTick(coreTick),
        .baseTick(baseTick)
    );

    always_comb begin
        logic wakeHalt;
        logic [7:0] ctrlByte;
        wakeHalt = 1'b0;
        ctrlByte = 8'h00;
        next_st = st;
        next_st.irqLevelForce = 1'b0;
        next_st.wdgResetReq = 1'b0;
        next_st.resume = 1'b0;

        // exit only on external, halt-exit capable irq, or reset
        wakeHalt = wake.extIrq | wake.haltExitIrq | wake.resetReq;

        case (st.mode)
            psm_pkg::PSM_RUN: begin
                if (cpuReq.haltInstr) begin
                    if (oscIrqEnable) begin
                        // oscillator irq guarantees an exit, so watchdog stays quiet
                        next_st.mode = psm_pkg::PSM_ACTIVE_HALT;
                        next_st.irqLevelForce = 1'b1;
                        next_st.cpuGate = 1'b0;
                        next_st.periphGate = 1'b0;
                    end else if (watchdogEnabled) begin
                        next_st.wdgResetReq = 1'b1;
                    end else begin
                        next_st.mode = psm_pkg::PSM_HALT;
                        next_st.irqLevelForce = 1'b1;
                        next_st.oscOn = 1'b0;
                        next_st.cpuGate = 1'b0;
                        next_st.periphGate = 1'b0;
                    end
                end else if (cpuReq.waitForInterruptInstr) begin
                    next_st.mode = psm_pkg::PSM_WAIT;
                    next_st.irqLevelForce = 1'b1;
                    next_st.cpuGate = 1'b0;
                end
            end
            psm_pkg::PSM_WAIT: begin
                if (wake.anyIrq | wake.resetReq) begin
                    next_st.mode = psm_pkg::PSM_RUN;
                    next_st.cpuGate = 1'b1;
                    next_st.resume = 1'b1;
                    next_st.resumeToReset = wake.resetReq;
                end
            end
            psm_pkg::PSM_HALT: begin
                if (wakeHalt) begin
                    next_st.mode = psm_pkg::PSM_STARTUP;
                    next_st.oscOn = 1'b1;
                    next_st.startCnt = '0;
                    next_st.wakeByReset = wake.resetReq;
                end
            end
            psm_pkg::PSM_ACTIVE_HALT: begin
                if (wakeHalt | wake.oscTimebaseIrq) begin
                    next_st.mode = psm_pkg::PSM_STARTUP;
                    next_st.startCnt = '0;
                    next_st.wakeByReset = wake.resetReq;
                end
            end
            psm_pkg::PSM_STARTUP: begin
                // a reset arriving during the delay still wins the vector
                if (wake.resetReq) begin
                    next_st.wakeByReset = 1'b1;
                end
                if (coreTick) begin
                    if (st.startCnt == STARTUP_LAST) begin
                        next_st.mode = psm_pkg::PSM_RUN;
                        next_st.cpuGate = 1'b1;
                        next_st.periphGate = 1'b1;
                        next_st.resume = 1'b1;
                        next_st.resumeToReset = st.wakeByReset | wake.resetReq;
                    end else begin
                        next_st.startCnt = psm_pkg::STARTUP_CNT_W'(st.startCnt + 1'b1);
                    end
                end
            end
            default: begin
                next_st.mode = psm_pkg::PSM_RUN;
                next_st.oscOn = 1'b1;
                next_st.cpuGate = 1'b1;
                next_st.periphGate = 1'b1;
            end
        endcase

        // write channel: address and data may arrive in either order
        if (axiReq.awvalid && !st.awHeld && !st.bvalid) begin
            next_st.awHeld = 1'b1;
            next_st.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && !st.wHeld && !st.bvalid) begin
            next_st.wHeld = 1'b1;
            next_st.wData = axiReq.wdata;
            next_st.wStrb = axiReq.wstrb;
        end
        if (st.awHeld && st.wHeld && !st.bvalid) begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bvalid = 1'b1;
            if (isCtrlAddr(st.awAddr)) begin
                next_st.bresp = psm_pkg::RESP_OKAY;
                ctrlByte = st.wData[7:0];
                // fields live in byte lane 0 only
                if (st.wStrb[0]) begin
                    next_st.ctrl = ctrlByte[psm_pkg::CTRL_W-1:0];
                end
            end else if (isStatusAddr(st.awAddr)) begin
                next_st.bresp = psm_pkg::RESP_OKAY;
            end else begin
                next_st.bresp = psm_pkg::RESP_SLVERR;
            end
        end
        if (st.bvalid && axiReq.bready) begin
            next_st.bvalid = 1'b0;
        end

        // read channel: one read at a time, data registered
        if (st.rvalid && axiReq.rready) begin
            next_st.rvalid = 1'b0;
        end
        if (axiReq.arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = 32'h0000_0000;
            next_st.rresp = psm_pkg::RESP_OKAY;
            if (isCtrlAddr(axiReq.araddr)) begin
                next_st.rdata[psm_pkg::CTRL_W-1:0] = st.ctrl;
            end else if (isStatusAddr(axiReq.araddr)) begin
                next_st.rdata[psm_pkg::STATUS_MODE_LSB +: 3] = st.mode;
                next_st.rdata[psm_pkg::STATUS_SLOW_BIT] = slowSel;
                next_st.rdata[psm_pkg::STATUS_CAUSE_BIT] = st.resumeToReset;
            end else begin
                next_st.rresp = psm_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st.mode <= psm_pkg::PSM_RUN;
            st.ctrl <= psm_pkg::CTRL_RESET;
            st.startCnt <= '0;
            st.wakeByReset <= 1'b0;
            st.oscOn <= 1'b1;
            st.cpuGate <= 1'b1;
            st.periphGate <= 1'b1;
            st.awHeld <= 1'b0;
            st.awAddr <= '0;
            st.wHeld <= 1'b0;
            st.wData <= 32'h0000_0000;
            st.wStrb <= 4'h0;
            st.bvalid <= 1'b0;
            st.bresp <= psm_pkg::RESP_OKAY;
            st.rvalid <= 1'b0;
            st.rdata <= 32'h0000_0000;
            st.rresp <= psm_pkg::RESP_OKAY;
            st.irqLevelForce <= 1'b0;
            st.wdgResetReq <= 1'b0;
            st.resume <= 1'b0;
            st.resumeToReset <= 1'b0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign axiRsp.awready = !st.awHeld && !st.bvalid;
    assign axiRsp.wready = !st.wHeld && !st.bvalid;
    assign axiRsp.bvalid = st.bvalid;
    assign axiRsp.bresp = st.bresp;
    assign axiRsp.arready = !st.rvalid;
    assign axiRsp.rvalid = st.rvalid;
    assign axiRsp.rdata = st.rdata;
    assign axiRsp.rresp = st.rresp;

    // all enables but oscEnable are qualified by clkEn so a frozen block clocks nothing
    assign clkGate.oscEnable = st.oscOn;
    assign clkGate.cpuClkEn = clkEn & st.cpuGate & coreTick;
    assign clkGate.periphClkEn = clkEn & st.periphGate & coreTick;
    // CAN stays on oscillator / 2; software parks it first when slowing down
    assign clkGate.canClkEn = clkEn & st.periphGate & baseTick;
    assign clkGate.timebaseClkEn = clkEn & st.oscOn & coreTick;

    assign cpuRsp.irqLevelForce = st.irqLevelForce;
    assign cpuRsp.irqLevel = psm_pkg::IRQ_LEVEL_ZERO;
    assign cpuRsp.wdgResetReq = st.wdgResetReq;
    assign cpuRsp.resume = st.resume;
    assign cpuRsp.resumeToReset = st.resumeToReset;

endmodule : psm_power_ctrl

// ===== psm_power_ctrl_monitor.sv
// assertion checker for the power saving mode controller
`timescale 1ns/1ps
module psm_power_ctrl_monitor #(
    parameter int STARTUP_LEN = 4096
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire psm_pkg::psm_axi_req_t axiReq,
    input wire psm_pkg::psm_axi_rsp_t axiRsp,
    input wire psm_pkg::psm_cpu_req_t cpuReq,
    input wire psm_pkg::psm_wake_t wake,
    input wire logic watchdogEnabled,
    input wire psm_pkg::psm_clk_gate_t clkGate,
    input wire psm_pkg::psm_cpu_rsp_t cpuRsp
);
    // two cycles of slack for where the count starts
    localparam int MINC = 2 * STARTUP_LEN - 2;
    logic wakeH;
    logic inStart;
    int unsigned upCnt;
    assign wakeH = wake.extIrq | wake.haltExitIrq | wake.resetReq;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            inStart <= 1'b0;
            upCnt <= 0;
        end else if ($rose(clkGate.oscEnable)) begin
            inStart <= 1'b1;
            upCnt <= 0;
        end else if (cpuRsp.resume) begin
            inStart <= 1'b0;
        end else if (inStart) begin
            upCnt <= upCnt + 1;
        end
    end
    sequence s_halt_wake;
        !clkGate.oscEnable && clkEn && wakeH;
    endsequence
    sequence s_halt_entry;
        $fell(clkGate.oscEnable);
    endsequence
    a_force_level: assert property (cpuRsp.irqLevelForce |-> cpuRsp.irqLevel == 2'h2
        && $past(cpuReq.haltInstr || cpuReq.waitForInterruptInstr))
        else $error("level force carries wrong pattern");
    a_halt_force: assert property (s_halt_entry |-> cpuRsp.irqLevelForce)
        else $error("halt entry without level force");
    a_osc_cause: assert property (s_halt_entry |-> $past(cpuReq.haltInstr) && !$past(watchdogEnabled))
        else $error("oscillator stopped without halt");
    a_halt_gated: assert property (!clkGate.oscEnable |-> !(clkGate.cpuClkEn || clkGate.periphClkEn
        || clkGate.canClkEn || clkGate.timebaseClkEn))
        else $error("clock enable active in halt");
    a_osc_restart: assert property (s_halt_wake |=> clkGate.oscEnable)
        else $error("oscillator not restarted on wake");
    a_halt_holds: assert property (!clkGate.oscEnable && !wakeH |=> !clkGate.oscEnable)
        else $error("halt left without wake source");
    a_wdg_cause: assert property (cpuRsp.wdgResetReq |-> $past(cpuReq.haltInstr)
        && $past(watchdogEnabled) && clkGate.oscEnable)
        else $error("watchdog reset without cause");
    a_startup_min: assert property (cpuRsp.resume && inStart |-> upCnt >= MINC)
        else $error("resume before restart delay");
    a_startup_gate: assert property (inStart && !cpuRsp.resume |-> !clkGate.cpuClkEn)
        else $error("cpu clocked during restart delay");
    a_can_rate: assert property (clkGate.canClkEn |=> !clkGate.canClkEn)
        else $error("can clock faster than half rate");
    a_resume_once: assert property (cpuRsp.resume |=> !cpuRsp.resume)
        else $error("resume longer than one cycle");
    a_b_stable: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
        else $error("write response dropped early");
endmodule : psm_power_ctrl_monitor

bind psm_power_ctrl psm_power_ctrl_monitor #(.STARTUP_LEN(STARTUP_LEN)) i_psm_power_ctrl_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .axiReq(axiReq), .axiRsp(axiRsp),
    .cpuReq(cpuReq), .wake(wake), .watchdogEnabled(watchdogEnabled), .clkGate(clkGate), .cpuRsp(cpuRsp));

// ===== psm_cpu_model.sv
// cpu core model issuing power instructions and holding level bits
`timescale 1ns/1ps
module psm_cpu_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic doHalt,
    input wire logic doWait,
    input wire psm_pkg::psm_cpu_rsp_t cpuRsp,
    output psm_pkg::psm_cpu_req_t cpuReq,
    output logic [1:0] levelBits,
    output logic running
);
    // a stopped cpu cannot issue anything
    assign cpuReq.haltInstr = doHalt & running;
    assign cpuReq.waitForInterruptInstr = doWait & running;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            running <= 1'b1;
            levelBits <= 2'h3;
        end else begin
            if (cpuReq.haltInstr || cpuReq.waitForInterruptInstr) begin
                running <= 1'b0;
            end
            if (cpuRsp.resume || cpuRsp.wdgResetReq) begin
                running <= 1'b1;
                levelBits <= 2'h3;  // routine exit masks again, so each force is seen
            end
            if (cpuRsp.irqLevelForce) begin
                levelBits <= cpuRsp.irqLevel;
            end
        end
    end
endmodule : psm_cpu_model

// ===== psm_power_ctrl_tb.sv
// self-checking bench for the power saving mode controller
`timescale 1ns/1ps
module psm_power_ctrl_tb;
    localparam int SL = 8;
    logic sys_clk, reset_n, clkEn, watchdogEnabled, doHalt, doWait, running;
    logic [1:0] levelBits;
    logic [1:0] rs;
    logic [31:0] rd;
    psm_pkg::psm_axi_req_t axiReq;
    psm_pkg::psm_axi_rsp_t axiRsp;
    psm_pkg::psm_cpu_req_t cpuReq;
    psm_pkg::psm_wake_t wake;
    psm_pkg::psm_clk_gate_t clkGate;
    psm_pkg::psm_cpu_rsp_t cpuRsp;
    int err_total, n_checks, cyc, p, n;
    psm_power_ctrl #(.STARTUP_LEN(SL)) i_psm_power_ctrl (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn),
        .axiReq(axiReq), .axiRsp(axiRsp), .cpuReq(cpuReq), .wake(wake), .watchdogEnabled(watchdogEnabled),
        .clkGate(clkGate), .cpuRsp(cpuRsp));
    psm_cpu_model i_psm_cpu_model (.sys_clk(sys_clk), .reset_n(reset_n), .doHalt(doHalt), .doWait(doWait),
        .cpuRsp(cpuRsp), .cpuReq(cpuReq), .levelBits(levelBits), .running(running));
    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= d;
        axiReq.bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
            if (axiRsp.bvalid) begin
                r = axiRsp.bresp;
                axiReq.bready <= 1'b0;
                break;
            end
        end
    endtask : axiWr
    task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        axiReq.rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
            if (axiRsp.rvalid) begin
                d = axiRsp.rdata;
                r = axiRsp.rresp;
                axiReq.rready <= 1'b0;
                break;
            end
        end
    endtask : axiRd
    function automatic logic tick(input int w);
        case (w)
            0: return clkGate.cpuClkEn;
            1: return clkGate.canClkEn;
            2: return clkGate.periphClkEn;
            3: return clkGate.timebaseClkEn;
            default: return cpuRsp.wdgResetReq;
        endcase
    endfunction : tick
    task automatic period(input int w, output int q);
        while (tick(w) !== 1'b1) @(negedge sys_clk);
        q = 0;
        do begin
            @(negedge sys_clk);
            q++;
        end while (tick(w) !== 1'b1);
    endtask : period
    task automatic count(input int w, input int k, output int c);
        c = 0;
        repeat (k) begin
            @(negedge sys_clk);
            if (tick(w) === 1'b1) c++;
        end
    endtask : count
    task automatic instr(input logic h);
        @(posedge sys_clk);
        doHalt <= h;
        doWait <= !h;
        @(posedge sys_clk);
        doHalt <= 1'b0;
        doWait <= 1'b0;
    endtask : instr
    task automatic waitResume(output int c);
        c = 0;
        do begin
            @(negedge sys_clk);
            c++;
        end while (cpuRsp.resume !== 1'b1);
    endtask : waitResume
    initial begin
        reset_n <= 1'b0;
        clkEn <= 1'b1;
        watchdogEnabled <= 1'b0;
        doHalt <= 1'b0;
        doWait <= 1'b0;
        wake <= '0;
        axiReq <= '0;
        axiReq.wstrb <= 4'hf;
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        axiRd(8'h00, rd, rs); check("ctrl reset", 32'h0000_0000, rd);
        axiRd(8'h10, rd, rs); check("unmapped resp", 32'h0000_0002, rs);
        axiWr(8'h10, 32'h0000_0001, rs);
        check("wr unmapped", 32'h0000_0002, rs);
        @(negedge sys_clk); period(0, p); period(0, p); check("run ratio", 2, p);
        @(posedge sys_clk) clkEn <= 1'b0;
        count(0, 6, n); check("frozen ticks", 0, n);
        @(posedge sys_clk) clkEn <= 1'b1;
        // can is assumed in standby before each slow write
        for (int s = 0; s < 4; s++) begin
            axiWr(8'h00, 32'(s * 2 + 1), rs);
            check("wr resp", 32'h0000_0000, rs);
            axiRd(8'h04, rd, rs); check("alias", 32'(s * 2 + 1), rd);
            @(negedge sys_clk); period(0, p); period(0, p); check("slow ratio", 4 << s, p);
            period(1, p); period(1, p); check("can ratio", 2, p);
        end
        axiWr(8'h00, 32'h0000_0000, rs);
        // a /32 period in flight must finish before /2 is back
        @(negedge sys_clk);
        period(0, p);
        period(0, p);
        check("run ratio back", 2, p);
        instr(1'b0);
        count(0, 8, n); check("wait cpu", 0, n);
        count(2, 8, n); check("wait periph", 4, n);
        check("wait level", 2, levelBits);
        axiRd(8'h08, rd, rs); check("wait mode", 1, rd & 32'h0000_0007);
        @(posedge sys_clk) wake.anyIrq <= 1'b1;
        waitResume(n); check("wait fast", 1, n <= 3);
        check("wait vector", 0, cpuRsp.resumeToReset);
        @(posedge sys_clk) wake <= '0;
        for (int k = 0; k < 3; k++) begin
            instr(1'b1);
            @(negedge sys_clk); check("halt osc", 0, clkGate.oscEnable);
            @(posedge sys_clk) wake <= 5'b00110;
            repeat (6) @(negedge sys_clk);
            check("halt kept", 0, clkGate.oscEnable);
            check("halt level", 2, levelBits);
            @(posedge sys_clk) wake <= {k == 0, k == 1, 2'b11, k == 2};
            waitResume(n); check("startup len", 1, n >= 2 * SL);
            check("halt vector", k == 2, cpuRsp.resumeToReset);
            @(posedge sys_clk) wake <= '0;
        end
        axiWr(8'h00, 32'h0000_0008, rs);
        @(posedge sys_clk) watchdogEnabled <= 1'b1;
        instr(1'b1);
        count(4, 4, n); check("ahalt no wdg", 0, n);
        check("ahalt osc", 1, clkGate.oscEnable);
        count(3, 8, n); check("ahalt timebase", 4, n);
        count(2, 8, n); check("ahalt periph", 0, n);
        axiRd(8'h08, rd, rs); check("ahalt mode", 3, rd & 32'h0000_0007);
        @(posedge sys_clk) wake.oscTimebaseIrq <= 1'b1;
        waitResume(n); check("ahalt vector", 0, cpuRsp.resumeToReset);
        @(posedge sys_clk) wake <= '0;
        axiWr(8'h00, 32'h0000_0000, rs);
        instr(1'b1);
        count(4, 4, n); check("wdg reset", 1, n);
        check("wdg osc", 1, clkGate.oscEnable);
        axiRd(8'h08, rd, rs); check("wdg mode", 0, rd & 32'h0000_0007);
        wrap_up();
    end
endmodule : psm_power_ctrl_tb
